//--- include/rco_pkg.sv
// package for the retimer channel override control block
// assumes a byte-wide register port and one system clock
package rco_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CUR_BOOST  = 8'h03;
	localparam logic [7:0] ADDR_TUNE_A     = 8'h08;
	localparam logic [7:0] ADDR_OVR_CTRL   = 8'h09;
	localparam logic [7:0] ADDR_TUNE_B     = 8'h0b;
	localparam logic [7:0] ADDR_LIMIT      = 8'h13;
	localparam logic [7:0] ADDR_SIGDET     = 8'h14;
	localparam logic [7:0] ADDR_OUT_SEL    = 8'h1e;
	localparam logic [7:0] ADDR_RATE       = 8'h2f;
	localparam logic [7:0] ADDR_ADAPT      = 8'h31;
	localparam logic [7:0] ADDR_SRCH_MODE  = 8'h36;
	localparam logic [7:0] ADDR_LOW_BOOST  = 8'h3a;

	// ----------------------------------------------------------------
	// reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_OUT_SEL     = 8'he0;
	localparam logic [7:0] RST_ADAPT       = 8'h20;
	localparam int         BIT_TUNE_OVR    = 7;
	localparam int         BIT_OUT_OVR     = 5;
	localparam int         BIT_QCLK_OVR    = 4;
	localparam int         BIT_LIMIT       = 2;
	localparam int         BIT_SD_FORCE_ON = 7;
	localparam int         BIT_SD_FORCE_OFF= 6;
	localparam int         BIT_QCLK_SEL    = 0;
	localparam logic [1:0] ADAPT_OFF       = 2'h0;
	localparam logic [1:0] SRCH_AUTO       = 2'h3;

	// divider codes: ratio = 2**code
	localparam logic [2:0] DIV_1           = 3'h0;
	localparam logic [2:0] DIV_8           = 3'h3;
	localparam logic [2:0] DIV_MAX         = 3'h4;

	// output source codes
	typedef enum logic [2:0] {
		SRC_RAW    = 3'h0,
		SRC_RETIME = 3'h1,
		SRC_ICLK   = 3'h2,
		SRC_QCLK   = 3'h3,
		SRC_PATGEN = 3'h4,
		SRC_SLOW   = 3'h5,
		SRC_BAD    = 3'h6,
		SRC_MUTE   = 3'h7
	} rco_src_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TUNE,
		ST_TRY,
		ST_LOCKED
	} rco_fsm_t;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rco_regreq_t;

	// analog channel status
	typedef struct packed {
		logic       sigPresent;
		logic       cdrLock;
		logic       tryFail;
		logic       tuneDone;
		logic [4:0] tuneCode;
	} rco_chstat_t;

	// controls toward the analog channel
	typedef struct packed {
		logic [7:0] eqBoost;
		logic       limitMode;
		logic [4:0] tuneCode;
		logic [2:0] divCode;
		logic       tuneSearch;
		logic [3:0] tuneRange;
		rco_src_t   outSrc;
		logic       chanPowerUp;
		logic       sigDetEff;
		logic       qClkEn;
		logic       oscFreeRun;
		logic       syncToInput;
		logic       dataUndef;
	} rco_chctl_t;

	typedef struct packed {
		rco_fsm_t   fsm;
		logic       useB;
		logic [7:0] curBoost;
		logic [7:0] tuneA;
		logic [7:0] ovrCtrl;
		logic [7:0] tuneB;
		logic [7:0] limitCtl;
		logic [7:0] sigDetCtl;
		logic [7:0] outSel;
		logic [7:0] rate;
		logic [7:0] adapt;
		logic [7:0] srchMode;
		logic [7:0] lowBoost;
		logic [7:0] rdData;
		rco_chctl_t ctl;
	} rco_state_t;

endpackage

//--- verilog/rco_channel_ctrl.sv
// override control for one retimer channel: boost source, coarse tuning
// search, output source selection and forced signal detect
// assumes all inputs synchronous to clk and a byte register port
//
// Behaviour
// - lowest-rate lock search takes boost from low-rate boost register
// - lock search copies low-rate boost into current boost register
// - after forcing, lost lock retries without touching boost
// - limiting register bit 2 puts final equalizer stage in limiting
// - search mode 11 first runs coarse tuning search over rate range
// - override tuning codes used only while override enable bit 7 set
// - override: try code A at divide 8, then code B at divide 1
// - keep alternating codes until lock or override enable cleared
// - output select codes: mute, invalid, slow, pattern, clocks, data
// - without override, select field drives output only when unlocked
// - with override, select field drives output even when locked
// - no signal detected powers channel down and mutes output
// - detect bit 7 set, bit 6 clear forces signal detect on
// - both detect bits clear returns detect to automatic circuitry
// - slow free-running clock selectable whenever output overridden
// - without input the oscillator free-runs on divider and tuning
// - when locked, clocks and pattern output are input-synchronous
// - data selected without input is flagged undefined
// - adapt mode in bits 6:5, zero disables boost overriding
// - lock lost restarts the full lock and adaptation sequence
// - reacquisition starts at the largest divider, the lowest rate
`timescale 1ns/100ps

module rco_channel_ctrl
	import rco_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire rco_regreq_t regReq,
	output      logic [7:0]  regRdData,
	// analog channel status and controls
	input  wire rco_chstat_t chStat,
	output      rco_chctl_t  chCtl
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rco_state_t st_ff;
	rco_state_t nxt_st;

	logic       tuneOvr;
	logic       outOvr;
	logic [1:0] adaptMode;
	logic       sdForceOn;
	logic       sdForceOff;
	logic       sigOk;
	logic       lowRateTry;
	rco_src_t   selField;

	// decoded controls from the current register contents
	always_comb begin
		tuneOvr    = st_ff.ovrCtrl[BIT_TUNE_OVR];
		outOvr     = st_ff.ovrCtrl[BIT_OUT_OVR];
		adaptMode  = st_ff.adapt[6:5];
		sdForceOn  = st_ff.sigDetCtl[BIT_SD_FORCE_ON];
		sdForceOff = st_ff.sigDetCtl[BIT_SD_FORCE_OFF];
		selField   = rco_src_t'(st_ff.outSel[7:5]);
		// force-off wins over force-on; both clear means automatic
		if (sdForceOff) begin
			sigOk = 1'b0;
		end else if (sdForceOn) begin
			sigOk = 1'b1;
		end else begin
			sigOk = chStat.sigPresent;
		end
		// boost overriding only when adaptation is on and not tuning by hand
		lowRateTry = (st_ff.fsm == ST_TRY) && !tuneOvr
			&& (adaptMode != ADAPT_OFF);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// register writes
		if (regReq.wr) begin
			case (regReq.addr)
				ADDR_CUR_BOOST: begin
					nxt_st.curBoost = regReq.wdata;
				end
				ADDR_TUNE_A: begin
					nxt_st.tuneA = regReq.wdata;
				end
				ADDR_OVR_CTRL: begin
					nxt_st.ovrCtrl = regReq.wdata;
				end
				ADDR_TUNE_B: begin
					nxt_st.tuneB = regReq.wdata;
				end
				ADDR_LIMIT: begin
					nxt_st.limitCtl = regReq.wdata;
				end
				ADDR_SIGDET: begin
					nxt_st.sigDetCtl = regReq.wdata;
				end
				ADDR_OUT_SEL: begin
					nxt_st.outSel = regReq.wdata;
				end
				ADDR_RATE: begin
					nxt_st.rate = regReq.wdata;
				end
				ADDR_ADAPT: begin
					nxt_st.adapt = regReq.wdata;
				end
				ADDR_SRCH_MODE: begin
					nxt_st.srchMode = regReq.wdata;
				end
				ADDR_LOW_BOOST: begin
					nxt_st.lowBoost = regReq.wdata;
				end
				default: begin
				end
			endcase
		end

		// the search copy wins over a software write in the same cycle,
		// so a forced boost must be made with adaptation off
		if (lowRateTry) begin
			nxt_st.curBoost = st_ff.lowBoost;
		end

		// register reads, unmapped offsets return zero
		if (regReq.rd) begin
			case (regReq.addr)
				ADDR_CUR_BOOST: nxt_st.rdData = st_ff.curBoost;
				ADDR_TUNE_A:    nxt_st.rdData = st_ff.tuneA;
				ADDR_OVR_CTRL:  nxt_st.rdData = st_ff.ovrCtrl;
				ADDR_TUNE_B:    nxt_st.rdData = st_ff.tuneB;
				ADDR_LIMIT:     nxt_st.rdData = st_ff.limitCtl;
				ADDR_SIGDET:    nxt_st.rdData = st_ff.sigDetCtl;
				ADDR_OUT_SEL:   nxt_st.rdData = st_ff.outSel;
				ADDR_RATE:      nxt_st.rdData = st_ff.rate;
				ADDR_ADAPT:     nxt_st.rdData = st_ff.adapt;
				ADDR_SRCH_MODE: nxt_st.rdData = st_ff.srchMode;
				ADDR_LOW_BOOST: nxt_st.rdData = st_ff.lowBoost;
				default:        nxt_st.rdData = RST_ZERO;
			endcase
		end

		// lock sequence
		case (st_ff.fsm)
			ST_IDLE: begin
				nxt_st.useB = 1'b0;
				if (sigOk && !tuneOvr
					&& st_ff.srchMode[5:4] == SRCH_AUTO) begin
					nxt_st.fsm = ST_TUNE;
				end else if (sigOk) begin
					nxt_st.fsm = ST_TRY;
				end
			end
			ST_TUNE: begin
				if (!sigOk) begin
					nxt_st.fsm = ST_IDLE;
				end else if (tuneOvr || chStat.tuneDone) begin
					nxt_st.fsm = ST_TRY;
				end
			end
			ST_TRY: begin
				if (!sigOk) begin
					nxt_st.fsm = ST_IDLE;
				end else if (chStat.cdrLock) begin
					nxt_st.fsm = ST_LOCKED;
				end else if (chStat.tryFail && tuneOvr) begin
					nxt_st.useB = !st_ff.useB;
				end
			end
			ST_LOCKED: begin
				// lost lock restarts the whole sequence at the lowest rate
				if (!sigOk || !chStat.cdrLock) begin
					nxt_st.fsm = ST_IDLE;
				end
			end
			default: begin
				nxt_st.fsm = ST_IDLE;
			end
		endcase

		// boost: fixed low-rate value during the search, else current
		if (lowRateTry) begin
			nxt_st.ctl.eqBoost = st_ff.lowBoost;
		end else begin
			nxt_st.ctl.eqBoost = st_ff.curBoost;
		end
		nxt_st.ctl.limitMode = st_ff.limitCtl[BIT_LIMIT];

		// coarse tuning code and divider
		nxt_st.ctl.tuneSearch = (st_ff.fsm == ST_TUNE);
		nxt_st.ctl.tuneRange  = st_ff.rate[7:4];
		if (tuneOvr) begin
			if (st_ff.useB) begin
				nxt_st.ctl.tuneCode = st_ff.tuneB[4:0];
				nxt_st.ctl.divCode  = DIV_1;
			end else begin
				nxt_st.ctl.tuneCode = st_ff.tuneA[4:0];
				nxt_st.ctl.divCode  = DIV_8;
			end
		end else begin
			if (chStat.tuneDone && st_ff.fsm == ST_TUNE) begin
				nxt_st.ctl.tuneCode = chStat.tuneCode;
			end
			// reacquisition begins at the largest divider
			nxt_st.ctl.divCode = DIV_MAX;
		end

		// output source selection
		nxt_st.ctl.sigDetEff   = sigOk;
		nxt_st.ctl.chanPowerUp = sigOk;
		if (!sigOk) begin
			nxt_st.ctl.outSrc = SRC_MUTE;
		end else if (outOvr) begin
			nxt_st.ctl.outSrc = selField;
		end else if (st_ff.fsm == ST_LOCKED) begin
			nxt_st.ctl.outSrc = SRC_RETIME;
		end else begin
			nxt_st.ctl.outSrc = selField;
		end
		// no undefined source ever reaches the driver
		if (nxt_st.ctl.outSrc == SRC_BAD) begin
			nxt_st.ctl.outSrc = SRC_MUTE;
		end
		nxt_st.ctl.qClkEn = st_ff.ovrCtrl[BIT_QCLK_OVR]
			&& st_ff.outSel[BIT_QCLK_SEL];

		// oscillator and synchronisation status
		nxt_st.ctl.oscFreeRun  = !chStat.sigPresent;
		nxt_st.ctl.syncToInput = (st_ff.fsm == ST_LOCKED);
		nxt_st.ctl.dataUndef   = !chStat.sigPresent && sigOk
			&& (nxt_st.ctl.outSrc == SRC_RAW
			|| nxt_st.ctl.outSrc == SRC_RETIME);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff                 <= '0;
			st_ff.fsm             <= ST_IDLE;
			st_ff.outSel          <= RST_OUT_SEL;
			st_ff.adapt           <= RST_ADAPT;
			st_ff.ctl.divCode     <= DIV_MAX;
			st_ff.ctl.outSrc      <= SRC_MUTE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign regRdData = st_ff.rdData;
	assign chCtl     = st_ff.ctl;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_searching;
		lowRateTry;
	endsequence

	sequence s_tryFail;
		st_ff.fsm == ST_TRY && tuneOvr && chStat.tryFail && sigOk
			&& !chStat.cdrLock;
	endsequence

	property p_lowBoostUsed;
		@(posedge clk) disable iff (rst)
		s_searching |=> chCtl.eqBoost == $past(st_ff.lowBoost);
	endproperty
	a_lowBoostUsed: assert property (p_lowBoostUsed)
		else $error("search boost not from low-rate register");

	property p_boostCopied;
		@(posedge clk) disable iff (rst)
		s_searching |=> st_ff.curBoost == $past(st_ff.lowBoost);
	endproperty
	a_boostCopied: assert property (p_boostCopied)
		else $error("low-rate boost not copied to current boost");

	property p_boostKept;
		@(posedge clk) disable iff (rst)
		(adaptMode == ADAPT_OFF && !(regReq.wr
			&& regReq.addr == ADDR_CUR_BOOST))
			|=> st_ff.curBoost == $past(st_ff.curBoost)
			&& chCtl.eqBoost == $past(st_ff.curBoost);
	endproperty
	a_boostKept: assert property (p_boostKept)
		else $error("boost changed with adaptation off");

	property p_codeA;
		@(posedge clk) disable iff (rst)
		(tuneOvr && !st_ff.useB) |=> chCtl.divCode == DIV_8
			&& chCtl.tuneCode == $past(st_ff.tuneA[4:0]);
	endproperty
	a_codeA: assert property (p_codeA)
		else $error("first override code not at divide 8");

	property p_alternate;
		@(posedge clk) disable iff (rst)
		s_tryFail |=> st_ff.useB != $past(st_ff.useB)
			##1 (!$past(tuneOvr) || chCtl.divCode
			== ($past(st_ff.useB) ? DIV_1 : DIV_8));
	endproperty
	a_alternate: assert property (p_alternate)
		else $error("override codes not alternated on failure");

	property p_noSigMute;
		@(posedge clk) disable iff (rst)
		!sigOk |=> chCtl.outSrc == SRC_MUTE && !chCtl.chanPowerUp;
	endproperty
	a_noSigMute: assert property (p_noSigMute)
		else $error("channel not muted without signal");

	property p_forceOn;
		@(posedge clk) disable iff (rst)
		(st_ff.sigDetCtl[7:6] == 2'h2) |=> chCtl.sigDetEff;
	endproperty
	a_forceOn: assert property (p_forceOn)
		else $error("forced signal detect not active");

	property p_override;
		@(posedge clk) disable iff (rst)
		(sigOk && outOvr && selField != SRC_BAD)
			|=> chCtl.outSrc == $past(selField);
	endproperty
	a_override: assert property (p_override)
		else $error("override select not applied");

	property p_unlockedSel;
		@(posedge clk) disable iff (rst)
		(sigOk && !outOvr && st_ff.fsm != ST_LOCKED
			&& selField != SRC_BAD)
			|=> chCtl.outSrc == $past(selField);
	endproperty
	a_unlockedSel: assert property (p_unlockedSel)
		else $error("unlocked output not from select field");

	property p_invalidMute;
		@(posedge clk) disable iff (rst)
		(sigOk && selField == SRC_BAD && (outOvr
			|| st_ff.fsm != ST_LOCKED)) |=> chCtl.outSrc == SRC_MUTE;
	endproperty
	a_invalidMute: assert property (p_invalidMute)
		else $error("invalid select code not muted");

	property p_relock;
		@(posedge clk) disable iff (rst)
		(st_ff.fsm == ST_LOCKED && !chStat.cdrLock)
			|=> st_ff.fsm == ST_IDLE;
	endproperty
	a_relock: assert property (p_relock)
		else $error("lost lock did not restart sequence");

endmodule

//--- dv/rco_chan_model.sv
// behavioural model of the analog side of one retimer channel
// assumes the block's chCtl outputs and two scenario knobs from the bench
`timescale 1ns/100ps

module rco_chan_model
	import rco_pkg::*;
#(
	parameter logic [4:0] FOUND_CODE = 5'h0d
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// scenario knobs
	input  wire logic        sigOn,
	input  wire logic        lockOk,
	// block side
	input  wire rco_chctl_t  chCtl,
	output      rco_chstat_t chStat
);
	logic [2:0] srchCnt_ff;
	logic [2:0] failCnt_ff;
	logic       done_ff;
	logic       fail_ff;
	logic       lock_ff;

	// ----------------------------------------------------------------
	// search, lock and failure timing
	// ----------------------------------------------------------------
	// search answers after four edges; failures come every eight edges
	always_ff @(posedge clk) begin
		if (rst) begin
			srchCnt_ff <= 3'h0;
			failCnt_ff <= 3'h0;
			done_ff    <= 1'b0;
			fail_ff    <= 1'b0;
			lock_ff    <= 1'b0;
		end else begin
			srchCnt_ff <= chCtl.tuneSearch ? srchCnt_ff + 3'h1 : 3'h0;
			done_ff    <= chCtl.tuneSearch && srchCnt_ff == 3'h3;
			failCnt_ff <= failCnt_ff + 3'h1;
			fail_ff    <= sigOn && !lockOk && failCnt_ff == 3'h7;
			lock_ff    <= sigOn && lockOk;
		end
	end

	// code is only meaningful with the done pulse, so scramble it otherwise
	assign chStat.sigPresent = sigOn;
	assign chStat.cdrLock    = lock_ff;
	assign chStat.tryFail    = fail_ff;
	assign chStat.tuneDone   = done_ff;
	assign chStat.tuneCode   = done_ff ? FOUND_CODE : ~FOUND_CODE;
endmodule

//--- dv/tb_top.sv
// self-checking bench for the channel override control block
// assumes the analog side model and byte register port of the package
`timescale 1ns/100ps

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
`define WAITC(c) begin for (n = 0; n < 60 && !(c); n++) begin \
	@(posedge clk); #1; end if (!(c)) begin err_total++; \
	$display("[FAIL] %0t wait timed out", $time); end end

module tb_top;
	import rco_pkg::*;

	logic        clk;
	logic        rst;
	logic        sigOn;
	logic        lockOk;
	rco_regreq_t regReq;
	logic [7:0]  regRdData;
	rco_chstat_t chStat;
	rco_chctl_t  chCtl;
	int          err_total;
	int          tests_run;
	int          n;

	// ----------------------------------------------------------------
	// design and far-side model
	// ----------------------------------------------------------------
	rco_channel_ctrl dut_u (
		.clk       (clk),
		.rst       (rst),
		.regReq    (regReq),
		.regRdData (regRdData),
		.chStat    (chStat),
		.chCtl     (chCtl)
	);

	rco_chan_model #(.FOUND_CODE(5'h0d)) model_u (
		.clk    (clk),
		.rst    (rst),
		.sigOn  (sigOn),
		.lockOk (lockOk),
		.chCtl  (chCtl),
		.chStat (chStat)
	);

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// reset also drops the signal so every scenario starts from idle
	task automatic doReset();
		@(posedge clk);
		#1;
		rst = 1'b1;
		sigOn = 1'b0;
		lockOk = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regReq = {1'b1, 1'b0, a, d};
		@(posedge clk);
		#1;
		regReq.wr = 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1;
		regReq = {1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1;
		regReq.rd = 1'b0;
		`CHK(regRdData, e)
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic scResetVals();
		doReset();
		`CHK(chCtl.outSrc, SRC_MUTE)
		`CHK(chCtl.divCode, DIV_MAX)
		rdChk(ADDR_OUT_SEL, RST_OUT_SEL);
		rdChk(ADDR_ADAPT, RST_ADAPT);
		rdChk(8'h50, 8'h00);
	endtask

	// every select code with override set, while locked
	task automatic scMux();
		logic [2:0] e;
		doReset();
		sigOn = 1'b1;
		lockOk = 1'b1;
		`WAITC(chCtl.syncToInput === 1'b1)
		`CHK(chCtl.syncToInput, 1'b1)
		wr(ADDR_OVR_CTRL, 8'h30);
		for (int c = 0; c < 8; c++) begin
			// pattern enable and q clock select stay set for every code
			wr(ADDR_OUT_SEL, {c[2:0], 5'h11});
			tick(3);
			e = (c == 6) ? 3'h7 : c[2:0];
			`CHK(chCtl.outSrc, rco_src_t'(e))
		end
		`CHK(chCtl.qClkEn, 1'b1)
	endtask

	// select field rules only while unlocked when not overridden
	task automatic scNoOvr();
		doReset();
		wr(ADDR_OUT_SEL, 8'h00);
		sigOn = 1'b1;
		tick(5);
		`CHK(chCtl.outSrc, SRC_RAW)
		lockOk = 1'b1;
		`WAITC(chCtl.syncToInput === 1'b1)
		tick(2);
		`CHK(chCtl.outSrc, SRC_RETIME)
	endtask

	// no input: muted, then forced detect and free-running output
	task automatic scSigDet();
		doReset();
		tick(2);
		`CHK(chCtl.chanPowerUp, 1'b0)
		`CHK(chCtl.oscFreeRun, 1'b1)
		wr(ADDR_SIGDET, 8'h80);
		wr(ADDR_OVR_CTRL, 8'h20);
		wr(ADDR_OUT_SEL, 8'h00);
		tick(3);
		`CHK(chCtl.sigDetEff, 1'b1)
		`CHK(chCtl.chanPowerUp, 1'b1)
		`CHK(chCtl.outSrc, SRC_RAW)
		`CHK(chCtl.dataUndef, 1'b1)
		wr(ADDR_SIGDET, 8'h00);
		tick(3);
		`CHK(chCtl.sigDetEff, 1'b0)
		`CHK(chCtl.outSrc, SRC_MUTE)
		// automatic detect follows the input, force-off overrides it
		sigOn = 1'b1;
		tick(3);
		`CHK(chCtl.sigDetEff, 1'b1)
		wr(ADDR_SIGDET, 8'hc0);
		tick(3);
		`CHK(chCtl.sigDetEff, 1'b0)
		`CHK(chCtl.outSrc, SRC_MUTE)
	endtask

	// override codes alternate with their divide ratios
	task automatic scTuneOvr();
		doReset();
		wr(ADDR_TUNE_A, 8'h0a);
		wr(ADDR_TUNE_B, 8'h15);
		wr(ADDR_OVR_CTRL, 8'h80);
		sigOn = 1'b1;
		`WAITC(chCtl.divCode === DIV_8)
		`CHK(chCtl.tuneCode, 5'h0a)
		`WAITC(chCtl.divCode === DIV_1)
		`CHK(chCtl.tuneCode, 5'h15)
		`WAITC(chCtl.divCode === DIV_8)
		`CHK(chCtl.tuneCode, 5'h0a)
	endtask

	// automatic coarse search over the rate range
	task automatic scSearch();
		doReset();
		wr(ADDR_RATE, 8'ha0);
		wr(ADDR_SRCH_MODE, 8'h30);
		sigOn = 1'b1;
		`WAITC(chCtl.tuneSearch === 1'b1)
		`CHK(chCtl.tuneRange, 4'ha)
		`WAITC(chCtl.tuneSearch === 1'b0)
		tick(2);
		`CHK(chCtl.tuneCode, 5'h0d)
	endtask

	// low-rate boost during search, then a forced boost survives lost lock
	task automatic scBoost();
		doReset();
		wr(ADDR_LOW_BOOST, 8'h5a);
		wr(ADDR_CUR_BOOST, 8'h11);
		sigOn = 1'b1;
		tick(5);
		`CHK(chCtl.eqBoost, 8'h5a)
		`CHK(chCtl.divCode, DIV_MAX)
		rdChk(ADDR_CUR_BOOST, 8'h5a);
		wr(ADDR_LIMIT, 8'h04);
		tick(3);
		`CHK(chCtl.limitMode, 1'b1)
		doReset();
		wr(ADDR_ADAPT, 8'h00);
		wr(ADDR_LOW_BOOST, 8'h33);
		wr(ADDR_CUR_BOOST, 8'h44);
		sigOn = 1'b1;
		lockOk = 1'b1;
		`WAITC(chCtl.syncToInput === 1'b1)
		lockOk = 1'b0;
		tick(6);
		`CHK(chCtl.syncToInput, 1'b0)
		`CHK(chCtl.eqBoost, 8'h44)
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		err_total = 0;
		tests_run = 0;
		rst = 1'b1;
		sigOn = 1'b0;
		lockOk = 1'b0;
		regReq = '0;
		scResetVals();
		scMux();
		scNoOvr();
		scSigDet();
		scTuneOvr();
		scSearch();
		scBoost();
		end_sim();
	end

	// whole run needs well under 2000 cycles
	initial begin
		#(20000 * 100);
		err_total++;
		end_sim();
	end
endmodule
